// *** midi_part_receive_filter.sv ***
// per-part midi receive filter with sustain actions, velocity curves and wishbone registers
// How it works
// [R1] controller 64 drives the selected sustain action
// [R2] hold mode keeps envelopes sustained while pedal on
// [R3] latch and mute actions follow the pedal
// [R4] inverted actions swap pedal on and off
// [R5] off setting ignores sustain messages
// [R6] pedal on steps program up or down
// [R7] pedal on steps arpeggiator pattern up or down
// [R8] freeze holds vocoder spectrum while pedal on
// [R9] freeze acts only for the carrier part
// [R10] channel is fixed 1-16, omni or global
// [R11] global uses global channel, omni accepts all
// [R12] note with page-down held learns fixed channel
// [R13] part program-change gate on accepts program changes
// [R14] global program-change disable blocks all program changes
// [R15] program-change gate also filters bank select
// [R16] controller gate on ignores controllers
// [R17] global control-change disable blocks all controllers except bank select
// [R18] controller gate never blocks bank select
// [R19] program change reloads effects only when program-driven
// [R20] velocity curves: normal, inverse, crossfades, thresholds
// [R21] inverse applies only with positive program sensitivity
// [R22] part routes to one of four output pairs
// [R23] sustain value 64 or more means pedal on
// [R24] settings held in registers, saved with performance
`include "part_filter_params.svh"
module midi_part_receive_filter #(
  parameter int CHAN_W = 5,
  parameter int VEL_PAIRS = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire part_filter_pkg::wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire part_filter_pkg::midi_msg_t midi_in,
  input wire logic page_down_held,
  input wire logic prog_vel_positive,
  output part_filter_pkg::midi_msg_t midi_out,
  output logic sustain_hold,
  output logic arp_latch,
  output logic arp_mute,
  output logic part_mute,
  output logic voc_freeze,
  output logic [6:0] program_num,
  output logic [6:0] pattern_num,
  output logic fx_reload,
  output logic [1:0] out_pair
);
  import part_filter_pkg::*;

  logic [31:0] cfg_reg;
  logic [31:0] glb_reg;
  logic [CHAN_W-1:0] chan_set;
  sus_action_t sus_mode;
  logic [3:0] vel_curve;
  logic [3:0] kind;
  logic [3:0] chan;
  logic chan_match;
  logic is_bank;
  logic pc_ok;
  logic cc_ok;
  logic accept;
  logic sus_msg;
  logic pedal_on;
  logic learn;
  logic wb_hit;
  logic wb_wr;
  logic [31:0] rd_data;
  logic [6:0] vel_mapped;

  assign sus_mode = sus_action_t'(cfg_reg[`CFG_SUS_LSB +: 4]);
  assign chan_set = cfg_reg[`CFG_CHAN_LSB +: CHAN_W];
  assign vel_curve = cfg_reg[`CFG_VEL_LSB +: 4];
  assign kind = midi_in.status[7:4];
  assign chan = midi_in.status[3:0];

  // channel match
  always_comb begin
    if (chan_set == `CHAN_OMNI) begin
      chan_match = 1'b1; // [R11]
    end else if (chan_set == `CHAN_GLOBAL) begin
      chan_match = (chan == glb_reg[`GLB_CHAN_LSB +: 4]); // [R11]
    end else begin
      chan_match = (chan_set < `CHAN_OMNI) && (chan == chan_set[3:0]); // [R10]
    end
  end

  // gates
  assign is_bank = (kind == `KIND_CC) &&
                   (midi_in.data1 == `BANK_MSB_CC || midi_in.data1 == `BANK_LSB_CC);
  assign pc_ok = cfg_reg[`CFG_PCG_BIT] && glb_reg[`GLB_PC_BIT]; // [R13] [R14] [R15]
  assign cc_ok = !cfg_reg[`CFG_CCG_BIT] && glb_reg[`GLB_CC_BIT]; // [R16] [R17]
  always_comb begin
    if (!midi_in.valid || !chan_match) begin
      accept = 1'b0;
    end else if (kind == `KIND_PC) begin
      accept = pc_ok; // [R13] [R14]
    end else if (is_bank) begin
      accept = pc_ok; // [R15] [R18]
    end else if (kind == `KIND_CC) begin
      accept = cc_ok; // [R16] [R17]
    end else begin
      accept = 1'b1;
    end
  end
  assign sus_msg = accept && kind == `KIND_CC && midi_in.data1 == `SUSTAIN_CC; // [R1]
  assign pedal_on = midi_in.data2 >= `PEDAL_ON_MIN; // [R23]
  assign learn = midi_in.valid && page_down_held && kind == `KIND_NOTE_ON; // [R12]

  // velocity curve
  always_comb begin
    logic [6:0] v;
    logic [6:0] thr;
    logic [3:0] idx;
    v = midi_in.data2;
    idx = 4'((vel_curve - 4'h4) >> 1);
    thr = 7'(`VEL_BASE + 7'(idx * `VEL_STEP));
    vel_mapped = v;
    unique case (vel_curve)
      4'h0: vel_mapped = v;
      4'h1: vel_mapped = (prog_vel_positive && v != 7'h00) ? 7'(8'h80 - {1'b0, v}) : v; // [R21]
      4'h2: vel_mapped = (v >= `VEL_SPLIT) ? v : 7'h00; // [R20]
      4'h3: vel_mapped = (v < `VEL_SPLIT) ? v : 7'h00; // [R20]
      default: begin
        if (idx < 4'(VEL_PAIRS)) begin
          if (vel_curve[0] == 1'b0) begin
            vel_mapped = (v <= thr) ? v : 7'h00; // [R20]
          end else begin
            vel_mapped = (v > thr) ? v : 7'h00; // [R20]
          end
        end
      end
    endcase
  end

  // accepted message out
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      midi_out <= '0;
    end else begin
      midi_out.valid <= accept;
      midi_out.status <= midi_in.status;
      midi_out.data1 <= midi_in.data1;
      midi_out.data2 <= (kind == `KIND_NOTE_ON) ? vel_mapped : midi_in.data2; // [R20]
    end
  end

  // sustain functions
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sustain_hold <= 1'b0;
      arp_latch <= 1'b0;
      arp_mute <= 1'b0;
      part_mute <= 1'b0;
      voc_freeze <= 1'b0;
    end else if (sus_msg) begin
      unique case (sus_mode)
        SUS_HOLD: sustain_hold <= pedal_on; // [R2]
        SUS_ARP_LATCH: arp_latch <= pedal_on; // [R3]
        SUS_ARP_MUTE: arp_mute <= pedal_on; // [R3]
        SUS_PART_MUTE: part_mute <= pedal_on; // [R3]
        SUS_HOLD_I: sustain_hold <= !pedal_on; // [R4]
        SUS_ARP_LATCH_I: arp_latch <= !pedal_on; // [R4]
        SUS_ARP_MUTE_I: arp_mute <= !pedal_on; // [R4]
        SUS_PART_MUTE_I: part_mute <= !pedal_on; // [R4]
        SUS_FREEZE: begin
          if (cfg_reg[`CFG_CARR_BIT]) begin
            voc_freeze <= pedal_on; // [R8] [R9]
          end
        end
        default: ; // [R5]
      endcase
    end
  end

  // program and pattern numbers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      program_num <= 7'h00;
      pattern_num <= 7'h00;
    end else if (accept && kind == `KIND_PC) begin
      program_num <= midi_in.data1; // [R13]
    end else if (sus_msg && pedal_on && sus_mode == SUS_PROG_UP) begin
      program_num <= 7'(program_num + 7'h01); // [R6]
    end else if (sus_msg && pedal_on && sus_mode == SUS_PROG_DN) begin
      program_num <= 7'(program_num - 7'h01); // [R6]
    end else if (sus_msg && pedal_on && sus_mode == SUS_PAT_UP) begin
      pattern_num <= 7'(pattern_num + 7'h01); // [R7]
    end else if (sus_msg && pedal_on && sus_mode == SUS_PAT_DN) begin
      pattern_num <= 7'(pattern_num - 7'h01); // [R7]
    end else if (wb_wr && wb_req.adr == `ADR_PROG_PAT) begin
      if (wb_req.sel[0]) begin
        program_num <= wb_req.dat[6:0]; // [R24]
      end
      if (wb_req.sel[1]) begin
        pattern_num <= wb_req.dat[`PP_PAT_LSB +: 7]; // [R24]
      end
    end
  end

  // effects reload and output pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fx_reload <= 1'b0;
      out_pair <= 2'h0;
    end else begin
      fx_reload <= accept && kind == `KIND_PC && cfg_reg[`CFG_FXP_BIT]; // [R19]
      out_pair <= cfg_reg[`CFG_OUT_LSB +: 2]; // [R22]
    end
  end

  // wishbone slave, one wait state
  assign wb_hit = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign wb_wr = wb_hit && wb_req.we;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= `CFG_RESET;
    end else begin
      if (wb_wr && wb_req.adr == `ADR_PART_CFG) begin
        for (int b = 0; b < 3; b++) begin
          if (wb_req.sel[b]) begin
            cfg_reg[b*8 +: 8] <= wb_req.dat[b*8 +: 8]; // [R24]
          end
        end
        cfg_reg[31:19] <= 13'h0000;
      end
      if (learn) begin
        cfg_reg[`CFG_CHAN_LSB +: CHAN_W] <= CHAN_W'(chan); // [R12]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      glb_reg <= `GLB_RESET;
    end else if (wb_wr && wb_req.adr == `ADR_GLOBAL && wb_req.sel[0]) begin
      glb_reg <= {26'h0, wb_req.dat[5:0]};
    end
  end

  always_comb begin
    unique case (wb_req.adr)
      `ADR_PART_CFG: rd_data = cfg_reg;
      `ADR_GLOBAL: rd_data = glb_reg;
      `ADR_STATUS: rd_data = {27'h0, voc_freeze, part_mute, arp_mute, arp_latch, sustain_hold};
      `ADR_PROG_PAT: rd_data = {17'h0, pattern_num, 1'b0, program_num};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= (wb_hit && !wb_req.we) ? rd_data : 32'h0000_0000;
    end
  end

  // checks
  sus_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    sus_msg && sus_mode == SUS_HOLD |=> sustain_hold == $past(pedal_on))
    else $error("hold does not follow pedal");
  inv_latch_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    sus_msg && sus_mode == SUS_ARP_LATCH_I |=> arp_latch != $past(pedal_on))
    else $error("inverted latch wrong");
  sus_off_a: assert property (@(posedge clk) disable iff (!rstn) // [R5]
    sus_msg && sus_mode == SUS_OFF |=> $stable({sustain_hold, arp_latch, arp_mute, part_mute, voc_freeze}))
    else $error("off mode changed a function");
  prog_up_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
    sus_msg && pedal_on && sus_mode == SUS_PROG_UP |=> program_num == 7'($past(program_num) + 7'h01))
    else $error("program step up wrong");
  glob_pc_a: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    midi_in.valid && kind == `KIND_PC && !glb_reg[`GLB_PC_BIT] |=> !midi_out.valid && !fx_reload)
    else $error("program change passed global block");
  cc_gate_a: assert property (@(posedge clk) disable iff (!rstn) // [R16]
    midi_in.valid && kind == `KIND_CC && !is_bank && cfg_reg[`CFG_CCG_BIT] |=> !midi_out.valid)
    else $error("controller passed part gate");
  bank_pass_a: assert property (@(posedge clk) disable iff (!rstn) // [R18]
    midi_in.valid && is_bank && chan_match && pc_ok |=> midi_out.valid)
    else $error("bank select blocked");
  freeze_carr_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    sus_msg && sus_mode == SUS_FREEZE && !cfg_reg[`CFG_CARR_BIT] |=> $stable(voc_freeze))
    else $error("freeze on non carrier part");
  chan_learn_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    learn |=> chan_set == CHAN_W'($past(chan)))
    else $error("channel learn failed");
  fx_src_a: assert property (@(posedge clk) disable iff (!rstn) // [R19]
    accept && kind == `KIND_PC && !cfg_reg[`CFG_FXP_BIT] |=> !fx_reload)
    else $error("effects reloaded in part mode");
  latch_follow_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    sus_msg && sus_mode == SUS_ARP_LATCH |=> arp_latch == $past(pedal_on))
    else $error("latch wrong");
  arp_mute_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    sus_msg && sus_mode == SUS_ARP_MUTE |=> arp_mute == $past(pedal_on))
    else $error("arp mute wrong");
  part_mute_a: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    sus_msg && sus_mode == SUS_PART_MUTE |=> part_mute == $past(pedal_on))
    else $error("part mute wrong");
  inv_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    sus_msg && sus_mode == SUS_HOLD_I |=> sustain_hold != $past(pedal_on))
    else $error("inverted hold wrong");
  inv_arp_mute_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
    sus_msg && sus_mode == SUS_ARP_MUTE_I |=> arp_mute != $past(pedal_on))
    else $error("inverted arp mute wrong");
  prog_down_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
    sus_msg && pedal_on && sus_mode == SUS_PROG_DN |=> program_num == 7'($past(program_num) - 7'h01))
    else $error("program step down wrong");
  pat_up_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    sus_msg && pedal_on && sus_mode == SUS_PAT_UP |=> pattern_num == 7'($past(pattern_num) + 7'h01))
    else $error("pattern step up wrong");
  freeze_on_a: assert property (@(posedge clk) disable iff (!rstn) // [R8]
    sus_msg && sus_mode == SUS_FREEZE && cfg_reg[`CFG_CARR_BIT] |=> voc_freeze == $past(pedal_on))
    else $error("freeze wrong");
  omni_pass_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
    midi_in.valid && chan_set == `CHAN_OMNI && kind == `KIND_NOTE_ON |=> midi_out.valid)
    else $error("omni note dropped");
  glob_chan_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
    midi_in.valid && chan_set == `CHAN_GLOBAL && chan != glb_reg[`GLB_CHAN_LSB +: 4] |=> !midi_out.valid)
    else $error("wrong global channel passed");
  fixed_chan_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
    midi_in.valid && chan_set < `CHAN_OMNI && chan != chan_set[3:0] |=> !midi_out.valid)
    else $error("wrong fixed channel passed");
  pc_gate_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    midi_in.valid && kind == `KIND_PC && !cfg_reg[`CFG_PCG_BIT] |=> !midi_out.valid && !fx_reload)
    else $error("program change passed part gate");
  bank_gate_a: assert property (@(posedge clk) disable iff (!rstn) // [R15]
    midi_in.valid && is_bank && !pc_ok |=> !midi_out.valid)
    else $error("bank select passed gate");
  glob_cc_a: assert property (@(posedge clk) disable iff (!rstn) // [R17]
    midi_in.valid && kind == `KIND_CC && !is_bank && !glb_reg[`GLB_CC_BIT] |=> !midi_out.valid)
    else $error("controller passed global block");
  fx_prog_a: assert property (@(posedge clk) disable iff (!rstn) // [R19]
    accept && kind == `KIND_PC && cfg_reg[`CFG_FXP_BIT] |=> fx_reload)
    else $error("effects not reloaded");
  pc_load_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    accept && kind == `KIND_PC |=> program_num == $past(midi_in.data1))
    else $error("program not loaded");
  vel_normal_a: assert property (@(posedge clk) disable iff (!rstn) // [R20]
    accept && kind == `KIND_NOTE_ON && vel_curve == 4'h0 |=> midi_out.data2 == $past(midi_in.data2))
    else $error("normal curve wrong");
  vel_xhigh_a: assert property (@(posedge clk) disable iff (!rstn) // [R20]
    accept && kind == `KIND_NOTE_ON && vel_curve == 4'h2 && midi_in.data2 < `VEL_SPLIT
    |=> midi_out.data2 == 7'h00)
    else $error("high crossfade wrong");
  inv_gate_a: assert property (@(posedge clk) disable iff (!rstn) // [R21]
    accept && kind == `KIND_NOTE_ON && vel_curve == 4'h1 && !prog_vel_positive
    |=> midi_out.data2 == $past(midi_in.data2))
    else $error("inverse without sensitivity");
  inv_curve_a: assert property (@(posedge clk) disable iff (!rstn) // [R21]
    accept && kind == `KIND_NOTE_ON && vel_curve == 4'h1 && prog_vel_positive && midi_in.data2 != 7'h00
    |=> {1'b0, midi_out.data2} + {1'b0, $past(midi_in.data2)} == 8'h80)
    else $error("inverse curve wrong");
  out_pair_a: assert property (@(posedge clk) disable iff (!rstn) // [R22]
    1'b1 |=> out_pair == $past(cfg_reg[`CFG_OUT_LSB +: 2]))
    else $error("output pair wrong");
  ack_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // [R24]
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (@(posedge clk) disable iff (!rstn) // [R24]
    wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  learn_fixed_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    learn |=> chan_set < `CHAN_OMNI)
    else $error("learn left fixed range");
  sus_only_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
    !sus_msg |=> $stable({sustain_hold, arp_latch, arp_mute, part_mute, voc_freeze}))
    else $error("function changed without sustain");
  pedal_thr_a: assert property (@(posedge clk) disable iff (!rstn) // [R23]
    sus_msg && sus_mode == SUS_HOLD && midi_in.data2 < `PEDAL_ON_MIN |=> !sustain_hold)
    else $error("low value held pedal");
endmodule : midi_part_receive_filter

// *** part_filter_params.svh ***
// register offsets, field positions, reset values and constants of the part receive filter
`ifndef PART_FILTER_PARAMS_SVH
`define PART_FILTER_PARAMS_SVH
`define ADR_PART_CFG 4'h0
`define ADR_GLOBAL 4'h4
`define ADR_STATUS 4'h8
`define ADR_PROG_PAT 4'hC
`define CFG_SUS_LSB 0
`define CFG_CHAN_LSB 4
`define CFG_PCG_BIT 9
`define CFG_CCG_BIT 10
`define CFG_VEL_LSB 11
`define CFG_OUT_LSB 15
`define CFG_FXP_BIT 17
`define CFG_CARR_BIT 18
`define CFG_RESET 32'h0002_0310
`define GLB_CHAN_LSB 0
`define GLB_PC_BIT 4
`define GLB_CC_BIT 5
`define GLB_RESET 32'h0000_0030
`define PP_PAT_LSB 8
`define CHAN_OMNI 5'h10
`define CHAN_GLOBAL 5'h11
`define SUSTAIN_CC 7'h40
`define PEDAL_ON_MIN 7'h40
`define BANK_MSB_CC 7'h00
`define BANK_LSB_CC 7'h20
`define VEL_BASE 7'h3C
`define VEL_STEP 7'h0A
`define VEL_SPLIT 7'h40
`define KIND_NOTE_OFF 4'h8
`define KIND_NOTE_ON 4'h9
`define KIND_CC 4'hB
`define KIND_PC 4'hC
`endif

// *** part_filter_pkg.sv ***
// types shared by the part receive filter
package part_filter_pkg;
  typedef enum logic [3:0] {
    SUS_HOLD = 4'h0, SUS_ARP_LATCH = 4'h1, SUS_ARP_MUTE = 4'h2, SUS_PART_MUTE = 4'h3,
    SUS_HOLD_I = 4'h4, SUS_ARP_LATCH_I = 4'h5, SUS_ARP_MUTE_I = 4'h6, SUS_PART_MUTE_I = 4'h7,
    SUS_PROG_UP = 4'h8, SUS_PROG_DN = 4'h9, SUS_PAT_UP = 4'hA, SUS_PAT_DN = 4'hB,
    SUS_FREEZE = 4'hC, SUS_OFF = 4'hD
  } sus_action_t;
  typedef struct packed {
    logic valid;
    logic [7:0] status;
    logic [6:0] data1;
    logic [6:0] data2;
  } midi_msg_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage : part_filter_pkg

// *** midi_sender.sv ***
// midi sender model standing at the far side of the part filter
module midi_sender (
  input wire logic clk,
  output part_filter_pkg::midi_msg_t msg
);
  timeunit 1ns;
  timeprecision 1ps;
  import part_filter_pkg::*;
  initial msg = '0;
  // one whole message per valid pulse, then the fields are released inverted
  task automatic send(input logic [7:0] st, input logic [6:0] d1, input logic [6:0] d2);
    @(posedge clk);
    msg <= '{valid: 1'b1, status: st, data1: d1, data2: d2};
    @(posedge clk);
    msg <= '{valid: 1'b0, status: ~st, data1: ~d1, data2: ~d2};
  endtask : send
endmodule : midi_sender

// *** midi_part_receive_filter_tb.sv ***
// self-checking testbench of the part receive filter
`include "part_filter_params.svh"
module midi_part_receive_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import part_filter_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  midi_msg_t midi_in;
  midi_msg_t midi_out;
  logic page_down_held = 1'b0;
  logic prog_vel_positive = 1'b0;
  logic sustain_hold, arp_latch, arp_mute, part_mute, voc_freeze, fx_reload;
  logic [6:0] program_num, pattern_num;
  logic [1:0] out_pair;
  logic [31:0] rd;
  int n_errors = 0;
  int compares = 0;
  always #20 clk = ~clk;
  midi_sender midi_sender_inst (.clk(clk), .msg(midi_in));
  midi_part_receive_filter midi_part_receive_filter_inst (.clk(clk), .rstn(rstn), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .midi_in(midi_in), .page_down_held(page_down_held),
    .prog_vel_positive(prog_vel_positive), .midi_out(midi_out), .sustain_hold(sustain_hold),
    .arp_latch(arp_latch), .arp_mute(arp_mute), .part_mute(part_mute), .voc_freeze(voc_freeze),
    .program_num(program_num), .pattern_num(pattern_num), .fx_reload(fx_reload), .out_pair(out_pair));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
  endtask : wb
  function automatic logic [31:0] cfg(input logic [3:0] sus, input logic [4:0] ch, input logic pc, input logic cc,
    input logic [3:0] vel, input logic [1:0] op, input logic fx, input logic car);
    return {13'h0, car, fx, op, vel, cc, pc, ch, sus};
  endfunction : cfg
  task automatic mi(input logic [7:0] st, input logic [6:0] d1, input logic [6:0] d2);
    midi_sender_inst.send(st, d1, d2);
    #1;
  endtask : mi
  task automatic t_reset();
    wb(1'b0, `ADR_PART_CFG, 32'h0);
    chk(rd, 32'h0002_0310);
    wb(1'b0, `ADR_GLOBAL, 32'h0);
    chk(rd, 32'h0000_0030);
    wb(1'b1, 4'h2, 32'hFFFF_FFFF);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_sustain();
    mi(8'hB0, 7'h40, 7'h40);
    chk(sustain_hold, 1'b1);
    mi(8'hB0, 7'h40, 7'h3F);
    chk(sustain_hold, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'hD, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(sustain_hold, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h1, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(arp_latch, 1'b1);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h7, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h00);
    chk(part_mute, 1'b1);
    mi(8'hB0, 7'h40, 7'h7F);
    chk(part_mute, 1'b0);
    $display("test sustain done");
  endtask : t_sustain
  task automatic t_step();
    wb(1'b1, `ADR_PART_CFG, cfg(4'h8, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    mi(8'hB0, 7'h40, 7'h7F);
    chk(program_num, 7'h02);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h9, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(program_num, 7'h01);
    wb(1'b1, `ADR_PART_CFG, cfg(4'hB, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(pattern_num, 7'h7F);
    wb(1'b1, `ADR_PART_CFG, cfg(4'hC, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(voc_freeze, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'hC, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b1));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(voc_freeze, 1'b1);
    mi(8'hB0, 7'h40, 7'h00);
    chk(voc_freeze, 1'b0);
    $display("test step done");
  endtask : t_step
  task automatic t_gates();
    wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hC0, 7'h05, 7'h00);
    chk({fx_reload, program_num}, 8'h85);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h11, 1'b1, 1'b1, 4'h0, 2'h0, 1'b0, 1'b0));
    mi(8'hC0, 7'h06, 7'h00);
    chk({fx_reload, program_num}, 8'h06);
    mi(8'hB0, 7'h20, 7'h01);
    chk(midi_out.valid, 1'b1);
    mi(8'hB0, 7'h40, 7'h7F);
    chk(sustain_hold, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h11, 1'b0, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hC0, 7'h07, 7'h00);
    chk(program_num, 7'h06);
    mi(8'hB0, 7'h00, 7'h01);
    chk(midi_out.valid, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    wb(1'b1, `ADR_GLOBAL, 32'h20);
    mi(8'hC0, 7'h08, 7'h00);
    chk(program_num, 7'h06);
    wb(1'b1, `ADR_GLOBAL, 32'h10);
    mi(8'hB0, 7'h40, 7'h7F);
    chk(sustain_hold, 1'b0);
    $display("test gates done");
  endtask : t_gates
  task automatic t_chan();
    wb(1'b1, `ADR_GLOBAL, 32'h37);
    mi(8'hB7, 7'h07, 7'h10);
    chk(midi_out.valid, 1'b1);
    mi(8'hB0, 7'h07, 7'h10);
    chk(midi_out.valid, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h03, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB7, 7'h07, 7'h10);
    chk(midi_out.valid, 1'b0);
    mi(8'hB3, 7'h07, 7'h10);
    chk(midi_out.valid, 1'b1);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h10, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB9, 7'h07, 7'h10);
    chk(midi_out.valid, 1'b1);
    @(posedge clk);
    page_down_held <= 1'b1;
    mi(8'h95, 7'h3C, 7'h40);
    @(posedge clk);
    page_down_held <= 1'b0;
    wb(1'b0, `ADR_PART_CFG, 32'h0);
    chk(rd[8:4], 5'h05);
    wb(1'b1, `ADR_GLOBAL, 32'h30);
    $display("test channel done");
  endtask : t_chan
  task automatic t_vel();
    logic [3:0] cv [8] = '{4'h0, 4'h1, 4'h4, 4'h4, 4'hF, 4'hF, 4'h2, 4'h3};
    logic [6:0] vi [8] = '{7'h50, 7'h20, 7'h3D, 7'h3C, 7'h6E, 7'h6F, 7'h3F, 7'h3F};
    logic [6:0] ve [8] = '{7'h50, 7'h60, 7'h00, 7'h3C, 7'h00, 7'h6F, 7'h00, 7'h3F};
    prog_vel_positive <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h11, 1'b1, 1'b0, cv[i], 2'h3, 1'b1, 1'b0));
      mi(8'h90, 7'h3C, vi[i]);
      chk(midi_out.data2, ve[i]);
    end
    chk(out_pair, 2'h3);
    $display("test velocity done");
  endtask : t_vel
  task automatic t_modes();
    wb(1'b1, `ADR_PART_CFG, cfg(4'h2, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(arp_mute, 1'b1);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h3, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(part_mute, 1'b1);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h4, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h00);
    chk(sustain_hold, 1'b1);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h5, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(arp_latch, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'h6, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(arp_mute, 1'b0);
    wb(1'b1, `ADR_PART_CFG, cfg(4'hA, 5'h11, 1'b1, 1'b0, 4'h0, 2'h0, 1'b1, 1'b0));
    mi(8'hB0, 7'h40, 7'h7F);
    chk(pattern_num, 7'h00);
    wb(1'b0, `ADR_STATUS, 32'h0);
    chk(rd, 32'h0000_0009);
    wb(1'b1, `ADR_PROG_PAT, 32'h0000_2A15);
    wb(1'b0, `ADR_PROG_PAT, 32'h0);
    chk(rd, 32'h0000_2A15);
    @(posedge clk);
    prog_vel_positive <= 1'b0;
    wb(1'b1, `ADR_PART_CFG, cfg(4'h0, 5'h11, 1'b1, 1'b0, 4'h1, 2'h0, 1'b1, 1'b0));
    mi(8'h90, 7'h3C, 7'h20);
    chk(midi_out.data2, 7'h20);
    chk({midi_out.status, 1'b0, midi_out.data1}, 16'h903C);
    $display("test modes done");
  endtask : t_modes
  task automatic t_rerst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk({sustain_hold, part_mute, program_num, pattern_num}, 32'h0);
    wb(1'b0, `ADR_PART_CFG, 32'h0);
    chk(rd, `CFG_RESET);
    $display("test reset again done");
  endtask : t_rerst
  task automatic end_of_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    #300000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_sustain();
    t_step();
    t_gates();
    t_chan();
    t_vel();
    t_modes();
    t_rerst();
    end_of_test();
  end
endmodule : midi_part_receive_filter_tb
